// >>> rtl/flash_cmd_host.sv
// Flash command host: turns software orders into flash command sequences
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module flash_cmd_host (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  output logic [19:0]      flashAddr,
  output logic [15:0]      flashDqOut,
  output logic             flashDqOe,
  input  wire logic [15:0] flashDqIn,
  output logic             flashCeN,
  output logic             flashWeN,
  output logic             flashOeN,
  output logic             byteModeN,
  input  wire logic        readyBusyN
);

  flash_ctl_pkg::host_reg_t q;
  flash_ctl_pkg::host_reg_t d;
  flash_ctl_pkg::step_t     cur;
  bus_cycle_if              cyc ();

  // One cycle of a command sequence
  function automatic flash_ctl_pkg::step_t mk(input logic [19:0] a, input logic [15:0] v,
                                              input logic rd, input logic last);
    flash_ctl_pkg::step_t s;
    s.addr = a;
    s.data = v;
    s.rd   = rd;
    s.last = last;
    return s;
  endfunction : mk

  // Sequence table: address and data of each step of each operation
  function automatic flash_ctl_pkg::step_t stepOf(input flash_ctl_pkg::op_t op,
                                                  input logic [2:0] n, input logic byteMode,
                                                  input logic [19:0] ta, input logic [15:0] td);
    logic [19:0] u1;
    logic [19:0] u2;
    logic [2:0]  k;
    u1 = byteMode ? `FC_UNLOCK1_BYTE : `FC_UNLOCK1_WORD;
    u2 = byteMode ? `FC_UNLOCK2_BYTE : `FC_UNLOCK2_WORD;
    k  = (n > 3'd2) ? n - 3'd3 : n;
    stepOf = mk(`FC_ANY_ADDR, `FC_D_RESET, 1'b0, 1'b1);
    case (op)
      flash_ctl_pkg::OP_ARRAY_READ:     stepOf = mk(ta, td, 1'b1, 1'b1);
      flash_ctl_pkg::OP_QUERY:          stepOf = mk(u1, `FC_D_QUERY, 1'b0, 1'b1);
      flash_ctl_pkg::OP_BYPASS_PROGRAM:
        stepOf = (n == 3'd0) ? mk(`FC_ANY_ADDR, `FC_D_PROGRAM, 1'b0, 1'b0)
                             : mk(ta, td, 1'b0, 1'b1);
      flash_ctl_pkg::OP_BYPASS_RESET:
        stepOf = (n == 3'd0) ? mk(`FC_ANY_ADDR, `FC_D_AUTOSEL, 1'b0, 1'b0)
                             : mk(`FC_ANY_ADDR, `FC_D_BYP_EXIT, 1'b0, 1'b1);
      flash_ctl_pkg::OP_SECTOR_ADD:     stepOf = mk(ta, `FC_D_SECTOR, 1'b0, 1'b1);
      flash_ctl_pkg::OP_SUSPEND:        stepOf = mk(`FC_ANY_ADDR, `FC_D_SUSPEND, 1'b0, 1'b1);
      flash_ctl_pkg::OP_RESUME:         stepOf = mk(`FC_ANY_ADDR, `FC_D_RESUME, 1'b0, 1'b1);
      flash_ctl_pkg::OP_RESET:          stepOf = mk(`FC_ANY_ADDR, `FC_D_RESET, 1'b0, 1'b1);
      default: begin
        // Unlocked sequences open with the two unlock writes
        if (k == 3'd0) begin
          stepOf = mk(u1, `FC_D_UNLOCK1, 1'b0, 1'b0);
        end else if (k == 3'd1) begin
          stepOf = mk(u2, `FC_D_UNLOCK2, 1'b0, 1'b0);
        end else if (op == flash_ctl_pkg::OP_AUTOSELECT) begin
          stepOf = mk(u1, `FC_D_AUTOSEL, 1'b0, 1'b0);
        end else if (op == flash_ctl_pkg::OP_PROGRAM) begin
          stepOf = mk(u1, `FC_D_PROGRAM, 1'b0, 1'b0);
        end else if (op == flash_ctl_pkg::OP_BYPASS_ENTER) begin
          stepOf = mk(u1, `FC_D_BYPASS, 1'b0, 1'b1);
        end else if (n == 3'd2) begin
          stepOf = mk(u1, `FC_D_ERASE_SETUP, 1'b0, 1'b0);
        end else if (op == flash_ctl_pkg::OP_CHIP_ERASE) begin
          stepOf = mk(u1, `FC_D_CHIP, 1'b0, 1'b1);
        end else begin
          stepOf = mk(ta, `FC_D_SECTOR, 1'b0, 1'b1);
        end
        // Fourth step of autoselect reads codes; of program writes the data
        if (n == 3'd3 && op == flash_ctl_pkg::OP_AUTOSELECT) begin
          stepOf = mk(ta, td, 1'b1, 1'b1);
        end else if (n == 3'd3 && op == flash_ctl_pkg::OP_PROGRAM) begin
          stepOf = mk(ta, td, 1'b0, 1'b1);
        end
      end
    endcase
  endfunction : stepOf

  // Whether the device, in its tracked mode, honours the operation
  function automatic logic allowed(input flash_ctl_pkg::host_reg_t s,
                                   input flash_ctl_pkg::op_t op);
    logic rdOnly;
    rdOnly  = (op == flash_ctl_pkg::OP_ARRAY_READ);
    allowed = 1'b1;
    if (op > flash_ctl_pkg::OP_RESUME) begin
      allowed = 1'b0;
    end else if (s.chipErase) begin
      allowed = rdOnly;
    end else if (s.window != 12'h000 && s.sectorErase && !s.susp) begin
      allowed = rdOnly || op == flash_ctl_pkg::OP_SECTOR_ADD
                || op == flash_ctl_pkg::OP_SUSPEND;
    end else if (s.sectorErase && !s.susp) begin
      allowed = rdOnly || op == flash_ctl_pkg::OP_SUSPEND;
    end else if (s.bypass) begin
      allowed = rdOnly || op == flash_ctl_pkg::OP_BYPASS_PROGRAM
                || op == flash_ctl_pkg::OP_BYPASS_RESET;
    end else if (s.query) begin
      allowed = rdOnly || op == flash_ctl_pkg::OP_RESET;
    end else if (s.autoMode) begin
      allowed = rdOnly || op == flash_ctl_pkg::OP_RESET
                || op == flash_ctl_pkg::OP_QUERY;
    end else begin
      case (op)
        flash_ctl_pkg::OP_SECTOR_ADD, flash_ctl_pkg::OP_SUSPEND,
        flash_ctl_pkg::OP_BYPASS_PROGRAM, flash_ctl_pkg::OP_BYPASS_RESET:
          allowed = 1'b0;
        flash_ctl_pkg::OP_RESUME: allowed = s.susp;
        flash_ctl_pkg::OP_QUERY: allowed = !s.susp;
        flash_ctl_pkg::OP_CHIP_ERASE, flash_ctl_pkg::OP_SECTOR_ERASE,
        flash_ctl_pkg::OP_BYPASS_ENTER: allowed = !s.susp;
        default: allowed = 1'b1;
      endcase
    end
  endfunction : allowed

  assign cur = stepOf(q.op, q.step, q.byteMode, q.regAddr, q.regData);

  // Command sequencer, mode tracking and register access
  always_comb begin
    d           = q;
    d.readyMeta = readyBusyN;
    d.readySync = q.readyMeta;
    d.busRdata  = 32'h0000_0000;
    if (q.window != 12'h000) begin
      d.window = q.window - 12'h001;
    end
    // Erase over once the pin reports ready after the window count runs out
    if ((q.sectorErase || q.chipErase) && !q.susp && q.window == 12'h000
        && q.readySync) begin
      d.sectorErase = 1'b0;
      d.chipErase   = 1'b0;
    end
    // Register reads
    if (regRd) begin
      if (regAddr == `FC_REG_ADDR) begin
        d.busRdata = {12'h000, q.regAddr};
      end else if (regAddr == `FC_REG_DATA) begin
        d.busRdata = {16'h0000, q.regData};
      end else if (regAddr == `FC_REG_CFG) begin
        d.busRdata = {31'h0000_0000, q.byteMode};
      end else if (regAddr == `FC_REG_STATUS) begin
        d.busRdata = {22'h00_0000, q.window != 12'h000, q.chipErase, q.sectorErase,
                      q.susp, q.query, q.autoMode, q.bypass, q.readySync, q.err,
                      q.st != flash_ctl_pkg::H_IDLE};
      end else if (regAddr == `FC_REG_RDATA) begin
        d.busRdata = {16'h0000, q.rdata};
      end
    end
    // Register writes; error clear comes before any new error so set wins
    if (regWr) begin
      if (regAddr == `FC_REG_ADDR) begin
        d.regAddr = regWdata[19:0];
      end else if (regAddr == `FC_REG_DATA) begin
        d.regData = regWdata[15:0];
      end else if (regAddr == `FC_REG_CFG) begin
        d.byteMode = regWdata[`FC_CFG_BYTE_BIT];
      end else if (regAddr == `FC_REG_STATUS) begin
        if (regWdata[`FC_STAT_ERR_BIT]) begin
          d.err = 1'b0;
        end
      end else if (regAddr == `FC_REG_CMD) begin
        if (q.st == flash_ctl_pkg::H_IDLE
            && allowed(q, flash_ctl_pkg::op_t'(regWdata[3:0]))) begin
          d.op   = flash_ctl_pkg::op_t'(regWdata[3:0]);
          d.step = 3'd0;
          d.st   = flash_ctl_pkg::H_ISSUE;
        end else begin
          d.err = 1'b1;
        end
      end
    end
    case (q.st)
      flash_ctl_pkg::H_ISSUE: begin
        d.st = flash_ctl_pkg::H_WAIT;
      end
      flash_ctl_pkg::H_WAIT: begin
        if (cyc.done) begin
          if (cur.rd) begin
            d.rdata = cyc.rdata;
          end
          if (cur.last) begin
            d.st = flash_ctl_pkg::H_IDLE;
            case (q.op)
              flash_ctl_pkg::OP_RESET: begin
                d.autoMode = 1'b0;
                d.query    = 1'b0;
              end
              flash_ctl_pkg::OP_AUTOSELECT:     d.autoMode = 1'b1;
              flash_ctl_pkg::OP_QUERY:          d.query = 1'b1;
              flash_ctl_pkg::OP_BYPASS_ENTER:   d.bypass = 1'b1;
              flash_ctl_pkg::OP_BYPASS_RESET:   d.bypass = 1'b0;
              flash_ctl_pkg::OP_CHIP_ERASE: begin
                d.chipErase = 1'b1;
                d.window    = 12'(`FC_GRACE_CYC);
              end
              flash_ctl_pkg::OP_SECTOR_ERASE, flash_ctl_pkg::OP_SECTOR_ADD: begin
                d.sectorErase = 1'b1;
                d.window      = 12'(`FC_WINDOW_CYC);
              end
              flash_ctl_pkg::OP_SUSPEND: begin
                d.susp   = 1'b1;
                d.window = (q.window != 12'h000) ? 12'(`FC_GRACE_CYC)
                                                 : 12'(`FC_SUSPEND_CYC);
              end
              flash_ctl_pkg::OP_RESUME: begin
                d.susp   = 1'b0;
                d.window = 12'(`FC_GRACE_CYC);
              end
              default: d.window = q.window;
            endcase
          end else begin
            d.step = q.step + 3'd1;
            d.st   = flash_ctl_pkg::H_ISSUE;
          end
        end
      end
      default: d.st = d.st;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Cycle request towards the pin engine
  assign cyc.req    = (q.st == flash_ctl_pkg::H_ISSUE);
  assign cyc.isRead = cur.rd;
  assign cyc.addr   = cur.addr;
  assign cyc.wdata  = cur.data;
  assign regRdata   = q.busRdata;
  assign byteModeN  = ~q.byteMode;

  flash_bus_cycle u_cycle (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .cyc        (cyc),
    .flashAddr  (flashAddr),
    .flashDqOut (flashDqOut),
    .flashDqOe  (flashDqOe),
    .flashDqIn  (flashDqIn),
    .flashCeN   (flashCeN),
    .flashWeN   (flashWeN),
    .flashOeN   (flashOeN)
  );

endmodule : flash_cmd_host

// >>> rtl/flash_ctl_map.svh
// Offsets, field positions, command codes and timing counts of the flash command host
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

// Software register offsets and widths
`define FC_REG_AW          8
`define FC_REG_CMD         8'h00
`define FC_REG_ADDR        8'h04
`define FC_REG_DATA        8'h08
`define FC_REG_CFG         8'h0C
`define FC_REG_STATUS      8'h10
`define FC_REG_RDATA       8'h14
`define FC_CFG_BYTE_BIT    0
`define FC_STAT_ERR_BIT    1

// Flash side widths
`define FC_ADDR_W          20
`define FC_DATA_W          16

// Unlock and command addresses
`define FC_UNLOCK1_WORD    20'h00555
`define FC_UNLOCK1_BYTE    20'h00AAA
`define FC_UNLOCK2_WORD    20'h002AA
`define FC_UNLOCK2_BYTE    20'h00555
`define FC_ANY_ADDR        20'h00000

// Command data codes
`define FC_D_UNLOCK1       16'h00AA
`define FC_D_UNLOCK2       16'h0055
`define FC_D_RESET         16'h00F0
`define FC_D_AUTOSEL       16'h0090
`define FC_D_QUERY         16'h0098
`define FC_D_PROGRAM       16'h00A0
`define FC_D_BYPASS        16'h0020
`define FC_D_BYP_EXIT      16'h0000
`define FC_D_ERASE_SETUP   16'h0080
`define FC_D_CHIP          16'h0010
`define FC_D_SECTOR        16'h0030
`define FC_D_SUSPEND       16'h00B0
`define FC_D_RESUME        16'h0030

// Timing: clock period and derived cycle counts
`define FC_CLK_NS          25
`define FC_T_WP_NS         35
`define FC_T_ACC_NS        70
`define FC_T_WINDOW_US     50
`define FC_T_SUSPEND_US    20
`define FC_SYNC_STAGES     2
`define FC_WP_CYC          ((`FC_T_WP_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_RD_CYC          ((`FC_T_ACC_NS + `FC_CLK_NS - 1) / `FC_CLK_NS + `FC_SYNC_STAGES)
`define FC_WINDOW_CYC      ((`FC_T_WINDOW_US * 1000) / `FC_CLK_NS)
`define FC_SUSPEND_CYC     ((`FC_T_SUSPEND_US * 1000) / `FC_CLK_NS)
`define FC_GRACE_CYC       4

`endif

// >>> rtl/flash_ctl_pkg.sv
// Types shared by the flash command host and its bus cycle engine
package flash_ctl_pkg;

  // Operations software may order, numbered in this order from 0
  typedef enum logic [3:0] {
    OP_RESET, OP_ARRAY_READ, OP_AUTOSELECT, OP_QUERY, OP_PROGRAM,
    OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_RESET, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME
  } op_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic        rd;
    logic        last;
  } step_t;

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_state_t;
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_state_t;

  typedef struct packed {
    eng_state_t  st;
    logic [3:0]  cnt;
    logic        rd;
    logic [19:0] pinAddr;
    logic [15:0] pinDout;
    logic        dqOe;
    logic        ceN;
    logic        weN;
    logic        oeN;
    logic [15:0] dqMeta;
    logic [15:0] dqSync;
    logic [15:0] rdata;
    logic        done;
  } eng_reg_t;

  typedef struct packed {
    host_state_t st;
    op_t         op;
    logic [2:0]  step;
    logic [19:0] regAddr;
    logic [15:0] regData;
    logic        byteMode;
    logic [15:0] rdata;
    logic        err;
    logic        bypass;
    logic        autoMode;
    logic        query;
    logic        susp;
    logic        sectorErase;
    logic        chipErase;
    logic [11:0] window;
    logic        readyMeta;
    logic        readySync;
    logic [31:0] busRdata;
  } host_reg_t;

endpackage : flash_ctl_pkg

// >>> rtl/bus_cycle_if.sv
// One flash bus cycle request and its completion between host and engine
`timescale 1ns/1ps
interface bus_cycle_if;
  logic        req;
  logic        isRead;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;

  modport master (output req, isRead, addr, wdata, input done, rdata);
  modport engine (input req, isRead, addr, wdata, output done, rdata);
endinterface : bus_cycle_if

// >>> rtl/flash_bus_cycle.sv
// Drives single write or read cycles on the flash pins
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module flash_bus_cycle (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  bus_cycle_if.engine             cyc,
  output logic [19:0]             flashAddr,
  output logic [15:0]             flashDqOut,
  output logic                    flashDqOe,
  input  wire logic [15:0]        flashDqIn,
  output logic                    flashCeN,
  output logic                    flashWeN,
  output logic                    flashOeN
);

  flash_ctl_pkg::eng_reg_t q;
  flash_ctl_pkg::eng_reg_t d;

  // Cycle sequencer: setup, strobe, hold
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.dqMeta = flashDqIn;
    d.dqSync = q.dqMeta;
    case (q.st)
      flash_ctl_pkg::E_IDLE: begin
        if (cyc.req) begin
          d.pinAddr = cyc.addr;
          d.pinDout = cyc.wdata;
          d.rd      = cyc.isRead;
          d.dqOe    = ~cyc.isRead;
          d.ceN     = 1'b0;
          d.st      = flash_ctl_pkg::E_SETUP;
        end
      end
      flash_ctl_pkg::E_SETUP: begin
        // Address latches on this falling write strobe
        d.weN = q.rd;
        d.oeN = ~q.rd;
        d.cnt = q.rd ? 4'(`FC_RD_CYC - 1) : 4'(`FC_WP_CYC - 1);
        d.st  = flash_ctl_pkg::E_STROBE;
      end
      flash_ctl_pkg::E_STROBE: begin
        if (q.cnt == 4'h0) begin
          if (q.rd) begin
            d.rdata = q.dqSync;
          end
          // Data still driven at the rising strobe edge
          d.weN = 1'b1;
          d.oeN = 1'b1;
          d.st  = flash_ctl_pkg::E_HOLD;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        d.ceN  = 1'b1;
        d.dqOe = 1'b0;
        d.done = 1'b1;
        d.st   = flash_ctl_pkg::E_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q     <= '0;
      q.ceN <= 1'b1;
      q.weN <= 1'b1;
      q.oeN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign flashAddr  = q.pinAddr;
  assign flashDqOut = q.pinDout;
  assign flashDqOe  = q.dqOe;
  assign flashCeN   = q.ceN;
  assign flashWeN   = q.weN;
  assign flashOeN   = q.oeN;
  assign cyc.done   = q.done;
  assign cyc.rdata  = q.rdata;

endmodule : flash_bus_cycle

// >>> tb/flash_cmd_host_asserts.sv
// Pin-level checks of the flash command host
`timescale 1ns/1ps
module flash_cmd_host_asserts (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [19:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic        flashDqOe,
  input wire logic        flashCeN,
  input wire logic        flashWeN,
  input wire logic        flashOeN,
  input wire logic        byteModeN
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [7:0]  prevD_q;
  logic [19:0] prevA_q;
  wire  [11:0] unl1 = byteModeN ? 12'h555 : 12'hAAA;
  wire  [11:0] unl2 = byteModeN ? 12'h2AA : 12'h555;
  // Byte and address of the previous write strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prevD_q <= 8'h00;
      prevA_q <= 20'h00000;
    end else if ($fell(flashWeN)) begin
      prevD_q <= flashDqOut[7:0];
      prevA_q <= flashAddr;
    end
  end
  // Strobe low two cycles, one hold cycle, then release
  sequence s_wrBody;
    !flashWeN ##1 flashWeN ##1 (flashCeN && !flashDqOe);
  endsequence
  // Output enable low five cycles
  sequence s_rdBody;
    !flashOeN [*5] ##1 flashOeN;
  endsequence
  a_unlock_order: assert property (
    $fell(flashWeN) && flashDqOut[7:0] == 8'h55 && flashAddr[11:0] == unl2 && prevD_q != 8'hA0
    |-> prevD_q == 8'hAA && prevA_q[11:0] == unl1) else $error("second unlock out of order");
  a_we_width: assert property (
    $fell(flashWeN) |-> ##1 s_wrBody) else $error("write strobe shape wrong");
  a_we_release: assert property (
    $rose(flashWeN) |-> !flashCeN && flashDqOe && $stable(flashAddr))
    else $error("write released without hold");
  a_setup_first: assert property (
    $fell(flashWeN) |-> !$past(flashCeN) && $past(flashDqOe) && $stable(flashAddr))
    else $error("write strobe without setup");
  a_wr_stable: assert property (
    !flashWeN && !$past(flashWeN) |-> $stable(flashAddr) && $stable(flashDqOut))
    else $error("write pins moved under strobe");
  a_read_shape: assert property (
    $fell(flashOeN) |-> s_rdBody) else $error("read strobe length wrong");
  a_read_quiet: assert property (
    !flashOeN |-> flashWeN && !flashDqOe && !flashCeN) else $error("read mixed with write");
  a_rdata_idle: assert property (
    !$past(regRd) |-> regRdata == 32'h0) else $error("read data outside its cycle");
endmodule : flash_cmd_host_asserts

bind flash_cmd_host flash_cmd_host_asserts flash_cmd_host_asserts_i (
  .clk_sys(clk_sys), .reset(reset), .regRd(regRd), .regRdata(regRdata),
  .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
  .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .byteModeN(byteModeN));

// >>> tb/flash_dev_model.sv
// Behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005A, // Arbitrary value
  parameter logic [15:0] DEV_CODE   = 16'h1234, // Arbitrary value
  parameter logic [7:0]  PROT_SECT  = 8'h12
) (
  input  wire logic [19:0] flashAddr,
  input  wire logic [15:0] flashDqOut,
  input  wire logic        flashCeN,
  input  wire logic        flashWeN,
  input  wire logic        flashOeN,
  input  wire logic        byteModeN,
  output logic      [15:0] flashDqIn,
  output logic             readyBusyN
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] rdv;
  logic [19:0] aLat;
  logic [7:0]  d;
  logic        pend = 1'b0;
  logic        u1;
  logic        u2;
  int          step = 0;
  int          mode = 0; // 1 autoselect 2 query 3 bypass 4 chip 5 suspended 6 sector
  int          gen = 0;
  initial readyBusyN = 1'b1;
  // Busy for a while, then a new mode unless superseded
  task automatic run(input int ns, input int nxt);
    fork
      begin
        int g;
        gen++;
        g = gen;
        readyBusyN = 1'b0;
        #(ns);
        if (g == gen) begin
          readyBusyN = 1'b1;
          mode = nxt;
        end
      end
    join_none
  endtask : run
  // Address latches on the falling strobe
  always @(negedge flashWeN) if (!flashCeN) aLat = flashAddr;
  // Each rising strobe is one command step
  always @(posedge flashWeN) if (!flashCeN) begin
    d = flashDqOut[7:0];
    u1 = (aLat[11:0] & {~byteModeN, 11'h7FF}) == (byteModeN ? 12'h555 : 12'hAAA);
    u2 = (aLat[11:0] & {~byteModeN, 11'h7FF}) == (byteModeN ? 12'h2AA : 12'h555);
    if (pend) begin
      mem[aLat] = flashDqOut;
      pend = 1'b0;
      run(1000, mode);
    end else if (mode == 6) begin
      if (d == 8'hB0) begin
        gen++;
        readyBusyN = 1'b1;
        mode = 5;
      end
    end else if (mode == 4) step = 0;
    else if (mode == 5 && d == 8'h30) begin
      mode = 6;
      run(10000, 0);
    end else if (d == 8'hF0 && mode != 3) begin
      mode = (mode == 5) ? 5 : 0;
      step = 0;
    end else if (mode == 3) begin
      if (d == 8'hA0) pend = 1'b1;
      else if (step == 9 && d == 8'h00) mode = 0;
      step = (d == 8'h90) ? 9 : 0;
    end else begin
      case (step)
        0: if (d == 8'hAA && u1) step = 1;
           else if (d == 8'h98 && u1 && mode < 2) mode = 2;
        1: step = (d == 8'h55 && u2) ? 2 : 0;
        2: begin
          step = 0;
          if (u1 && d == 8'h90) mode = 1;
          if (u1 && d == 8'hA0) pend = 1'b1;
          if (u1 && d == 8'h20) mode = 3;
          if (u1 && d == 8'h80) step = 3;
        end
        3: step = (d == 8'hAA && u1) ? 4 : 0;
        4: step = (d == 8'h55 && u2) ? 5 : 0;
        default: begin
          step = 0;
          if (d == 8'h10 && u1) run(5000, 0);
          if (d == 8'h10 && u1) mode = 4;
          if (d == 8'h30) run(60000, 0);
          if (d == 8'h30) mode = 6;
        end
      endcase
    end
  end
  // Array, identity or protection data for a read
  always @* begin
    if (mode == 1 && flashAddr[7:0] == (byteModeN ? 8'h02 : 8'h04))
      rdv = {15'h0, flashAddr[19:12] == PROT_SECT};
    else if (mode == 1)
      rdv = (flashAddr[7:0] == 8'h00) ? MAKER_CODE : DEV_CODE;
    else
      rdv = mem.exists(flashAddr) ? mem[flashAddr] : 16'hFFFF;
  end
  assign flashDqIn = (!flashCeN && !flashOeN) ? rdv : ~rdv;
endmodule : flash_dev_model

// >>> tb/testbench.sv
// Self-checking bench of the flash command host with a device model
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  logic [19:0] flashAddr;
  logic [15:0] flashDqOut;
  logic [15:0] flashDqIn;
  logic        flashDqOe, flashCeN, flashWeN, flashOeN, byteModeN, readyBusyN;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  flash_cmd_host flash_cmd_host_i (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .byteModeN(byteModeN), .readyBusyN(readyBusyN));
  flash_dev_model flash_dev_model_i (.flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .byteModeN(byteModeN),
    .flashDqIn(flashDqIn), .readyBusyN(readyBusyN));
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    compares++;
    if ((v & m) !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t reg %h got %h want %h", $time, a, v & m, e);
    end
  endtask : chk
  // Poll status until the masked bits settle, bounded
  task automatic waitSt(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    int k;
    k = 0;
    do begin
      rd(8'h10, v);
      k++;
    end while ((v & m) !== e && k < 6000);
    if ((v & m) !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t status stuck at %h", $time, v);
    end
  endtask : waitSt
  // Load address and data, order one operation, wait for it to finish
  task automatic go(input logic [3:0] o, input logic [31:0] a, input logic [31:0] v);
    wr(8'h04, a);
    wr(8'h08, v);
    wr(8'h00, {28'h0, o});
    waitSt(32'h1, 32'h0);
  endtask : go
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    // Ready pin synchroniser fills before the first status read
    @(posedge clk_sys);
    chk(8'h10, 32'h3FF, 32'h004);
    wr(8'h04, 32'hABCDE);
    chk(8'h04, 32'hFFFFF, 32'hABCDE);
    chk(8'h18, 32'hFFFFFFFF, 32'h0);
    go(4'h4, 32'h12345, 32'hBEEF);
    waitSt(32'h4, 32'h4);
    go(4'h1, 32'h12345, 32'h0);
    chk(8'h14, 32'hFFFF, 32'hBEEF);
    go(4'h2, 32'h0, 32'h0);
    chk(8'h14, 32'hFFFF, 32'h005A);
    go(4'h3, 32'h0, 32'h0);
    chk(8'h10, 32'h20, 32'h20);
    go(4'h0, 32'h0, 32'h0);
    chk(8'h10, 32'h30, 32'h0);
    go(4'h2, 32'h12002, 32'h0);
    chk(8'h14, 32'hFFFF, 32'h1);
    go(4'h1, 32'h33002, 32'h0);
    chk(8'h14, 32'hFFFF, 32'h0);
    go(4'h0, 32'h0, 32'h0);
    go(4'h5, 32'h0, 32'h0);
    chk(8'h10, 32'h8, 32'h8);
    go(4'h6, 32'h00400, 32'h1234);
    waitSt(32'h4, 32'h4);
    go(4'h7, 32'h0, 32'h0);
    chk(8'h10, 32'h8, 32'h0);
    go(4'h1, 32'h00400, 32'h0);
    chk(8'h14, 32'hFFFF, 32'h1234);
    wr(8'h0C, 32'h1);
    go(4'h4, 32'h00801, 32'h00A5);
    compares++;
    if (byteModeN !== 1'b0) begin
      n_errors++;
      $display("CHECK FAILED t=%0t byte mode pin high", $time);
    end
    waitSt(32'h4, 32'h4);
    go(4'h1, 32'h00801, 32'h0);
    chk(8'h14, 32'hFF, 32'hA5);
    wr(8'h0C, 32'h0);
    go(4'h9, 32'h23000, 32'h0);
    chk(8'h10, 32'h80, 32'h80);
    go(4'hA, 32'h24000, 32'h0);
    chk(8'h10, 32'h280, 32'h280);
    go(4'hB, 32'h0, 32'h0);
    chk(8'h10, 32'h44, 32'h44);
    go(4'hC, 32'h0, 32'h0);
    chk(8'h10, 32'h40, 32'h0);
    waitSt(32'h80, 32'h0);
    go(4'h8, 32'h0, 32'h0);
    go(4'hB, 32'h0, 32'h0);
    chk(8'h10, 32'h102, 32'h102);
    wr(8'h10, 32'h2);
    waitSt(32'h100, 32'h0);
    go(4'hD, 32'h0, 32'h0);
    chk(8'h10, 32'h3, 32'h2);
    close_out();
  end
endmodule : testbench
